// ==== dv/dram_buffer_model.sv ====
`timescale 1ns/1ps

module dram_buffer_model
(
	// DRAM pins
	input  wire logic        row_strobe_n,
	input  wire logic        column_strobe_n,
	input  wire logic        periph_write_strobe_n,
	input  wire logic        periph_read_strobe_n,
	input  wire logic [7:0]  sys_addr_low,
	input  wire logic [1:0]  mem_addr_high,
	input  wire logic [15:0] sys_data_bus_out,
	output logic [15:0]      sys_data_bus_in,
	// Peripheral width
	input  wire logic        wide16,
	output logic             wide_transfer_n,
	// Word seen as the write strobe rises
	output logic [15:0]      pw_seen
);
	logic [15:0] mem [int];
	logic [9:0]  row;
	logic [19:0] loc;
	logic [15:0] rdat;
	logic [15:0] lastv = 16'h0000;

	assign wide_transfer_n = ~wide16;
	// Released bus shows the inverse of the last word so a stale latch cannot pass
	assign sys_data_bus_in = (!column_strobe_n && !periph_read_strobe_n) ? rdat : ~lastv;

	// Column strobe already low means refresh, so the row is not taken
	always @(negedge row_strobe_n)
		if (column_strobe_n === 1'b1)
			row = {mem_addr_high, sys_addr_low};

	always @(negedge column_strobe_n)
	begin
		loc = {row, mem_addr_high, sys_addr_low};
		if (!row_strobe_n && !periph_write_strobe_n)
			mem[loc] = sys_data_bus_out;
		rdat = mem.exists(loc) ? mem[loc] : ~lastv;
	end

	always @(posedge column_strobe_n)
		lastv = rdat;

	// Peripheral side takes its data on the rising write strobe
	always @(posedge periph_write_strobe_n)
		if (row_strobe_n === 1'b1)
			pw_seen = sys_data_bus_out;
endmodule

// ==== dv/peripheral_bus_dram_sequencer_bench.sv ====
`timescale 1ns/1ps

module peripheral_bus_dram_sequencer_bench
	import dram_seq_pkg::*;
();
	logic        ref_clk, sys_rst, clk_en, periph_width_sel, addr_auto_step, cmd_valid;
	logic [1:0]  bclk_div_sel, mem_width_sel, mem_addr_high, sys_data_bus_oe;
	logic [3:0]  cs_line_cfg, gpo_level, periph_select_n;
	seq_cmd_t    cmd;
	logic        cmd_ready, rd_valid, dma_ack_n, term_count, bus_clk, wide_transfer_n;
	logic        periph_write_strobe_n, periph_read_strobe_n, row_strobe_n, column_strobe_n;
	logic [7:0]  sys_addr_low;
	logic [15:0] rd_data, sys_data_bus_in, sys_data_bus_out, pw_seen;
	logic [12:0] hist [0:8191];
	int          hn = 0;
	int          st, per;
	int          failures = 0;
	int          n_compared = 0;

	peripheral_bus_dram_sequencer uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.bclk_div_sel(bclk_div_sel), .periph_width_sel(periph_width_sel), .mem_width_sel(mem_width_sel),
		.addr_auto_step(addr_auto_step), .cs_line_cfg(cs_line_cfg), .gpo_level(gpo_level),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid),
		.dma_ack_n(dma_ack_n), .term_count(term_count), .bus_clk(bus_clk),
		.periph_select_n(periph_select_n), .periph_write_strobe_n(periph_write_strobe_n),
		.periph_read_strobe_n(periph_read_strobe_n), .wide_transfer_n(wide_transfer_n),
		.sys_addr_low(sys_addr_low), .mem_addr_high(mem_addr_high), .row_strobe_n(row_strobe_n),
		.column_strobe_n(column_strobe_n), .sys_data_bus_in(sys_data_bus_in),
		.sys_data_bus_out(sys_data_bus_out), .sys_data_bus_oe(sys_data_bus_oe));

	dram_buffer_model dram (.row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
		.periph_write_strobe_n(periph_write_strobe_n), .periph_read_strobe_n(periph_read_strobe_n),
		.sys_addr_low(sys_addr_low), .mem_addr_high(mem_addr_high), .sys_data_bus_out(sys_data_bus_out),
		.sys_data_bus_in(sys_data_bus_in), .wide16(periph_width_sel), .wide_transfer_n(wide_transfer_n),
		.pw_seen(pw_seen));

	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// ----------------------------------------
	// Pin history, one entry per system clock
	// ----------------------------------------
	// Low in a bit means active: strobes, selects, driving, terminal count, read valid; top bit is the bus clock
	always @(posedge ref_clk)
	begin
		hist[hn] = {bus_clk, ~rd_valid, periph_select_n, ~sys_data_bus_oe[0], ~term_count, dma_ack_n,
			periph_read_strobe_n, periph_write_strobe_n, row_strobe_n, column_strobe_n};
		if (hn < 8191)
			hn = hn + 1;
	end

	function automatic int fall(int b, int s);
		for (int i = s; i < hn; i++)
			if (hist[i][b] === 1'b0)
				return i;
		return -1;
	endfunction

	function automatic int lowrun(int b, int s);
		int n;
		n = 0;
		while (s + n < hn && hist[s+n][b] === 1'b0)
			n++;
		return n;
	endfunction

	function automatic int falls(int b, int s);
		int n;
		n = 0;
		for (int i = s + 1; i < hn; i++)
			if (hist[i][b] === 1'b0 && hist[i-1][b] === 1'b1)
				n++;
		return n;
	endfunction

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Request held until the edge that sees ready, then wait for idle
	task automatic run(input op_kind_t k, input logic [19:0] a, input logic [15:0] d,
		input logic [1:0] t, input logic lst);
		int i;
		@(posedge ref_clk);
		cmd <= '{kind:k, target:t, addr_load:1'b1, last:lst, addr:a, data:d};
		cmd_valid <= 1'b1;
		i = 0;
		do
		begin
			@(negedge ref_clk);
			i++;
		end
		while (cmd_ready !== 1'b1 && i < 50);
		if (cmd_ready !== 1'b1)
		begin
			chk(cmd_ready, 1'b1);
			tally_and_finish();
		end
		st = hn;
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		repeat (3) @(negedge ref_clk);
		i = 0;
		while (cmd_ready !== 1'b1 && i < 600)
		begin
			@(negedge ref_clk);
			i++;
		end
		if (i >= 600)
		begin
			chk(cmd_ready, 1'b1);
			tally_and_finish();
		end
		repeat (2) @(posedge ref_clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_pwrite;
		int c, w, o, t, b;
		logic [7:0] a, e;
		cs_line_cfg <= 4'h5;
		gpo_level <= 4'h2;
		for (int dv = 0; dv < 4; dv++)
		begin
			per = (dv == 0) ? 2 : (dv == 1) ? 3 : (dv == 2) ? 5 : 6;
			t = dv[0] ? 2 : 0;
			a = (dv == 3) ? 8'hFF : 8'h40 + 8'(dv);
			e = (dv == 1) ? a : a + 8'h01;
			bclk_div_sel <= dv[1:0];
			addr_auto_step <= (dv != 1);
			run(K_PWR, {12'h000, a}, {8'hC3, a}, t[1:0], 1'b0);
			c = fall(7 + t, st);
			w = fall(2, st);
			o = fall(6, st);
			chk(w - c, per);
			chk(lowrun(2, w), 2 * per);
			chk(o - c, per);
			chk(lowrun(6, o), 3 * per);
			chk(lowrun(7 + t, c), 4 * per);
			chk(sys_addr_low, e);
			chk({periph_select_n[3], periph_select_n[1]}, 2'b01);
			chk(pw_seen, {8'hC3, a});
			b = fall(12, st);
			b = fall(12, b + lowrun(12, b));
			chk(fall(12, b + lowrun(12, b)) - b, per);
		end
		$display("peripheral write test done");
	endtask

	task automatic t_dram;
		int r, c, w, e, nb;
		logic [19:0] a;
		logic [7:0] d;
		bclk_div_sel <= 2'h0;
		per = 2;
		for (int m = 0; m < 3; m++)
		begin
			mem_width_sel <= m[1:0];
			nb = (m == 0) ? 2 : 1;
			a = 20'hB7F00 + 20'(m * 16);
			d = 8'h5A + 8'(m);
			run(K_MWR, a, {8'h00, d}, 2'h0, 1'b0);
			r = fall(1, st);
			w = fall(2, st);
			c = fall(0, st);
			chk(w - r, 0);
			chk(c - r, 2 * per);
			chk(lowrun(0, c), 2 * per);
			chk(falls(0, st), nb);
			chk(w + lowrun(2, w) - r - lowrun(1, r), 1);
			chk(fall(11, st), -1);
			run(K_MRD, a, 16'h0000, 2'h0, 1'b0);
			r = fall(1, st);
			c = fall(0, st);
			e = c + lowrun(0, c);
			chk(fall(3, st) - r, 0);
			chk(lowrun(0, c), 2 * per);
			w = fall(3, st);
			chk(fall(11, st), w + lowrun(3, w));
			chk(lowrun(11, fall(11, st)), 1);
			if (nb > 1)
				chk(fall(0, e) - e, per);
			chk(rd_data[7:0], d);
		end
		$display("dram host access test done");
	endtask

	task automatic t_refresh;
		int c, r;
		bclk_div_sel <= 2'h1;
		per = 3;
		run(K_REF, 20'h00000, 16'h0000, 2'h0, 1'b0);
		c = fall(0, st);
		r = fall(1, st);
		chk(r - c, per);
		chk(lowrun(0, c), 3 * per);
		chk(lowrun(1, r), 2 * per);
		$display("refresh test done");
	endtask

	task automatic t_dma;
		int a;
		int ln [5] = '{16, 19, 16, 19, 25};
		int nb [5] = '{1, 2, 1, 2, 4};
		logic [2:0] ws [5] = '{3'b001, 3'b000, 3'b111, 3'b101, 3'b100};
		bclk_div_sel <= 2'h0;
		per = 2;
		for (int i = 0; i < 5; i++)
		begin
			{periph_width_sel, mem_width_sel} <= ws[i];
			run(i[0] ? K_DMA_WR : K_DMA_RD, 20'h0C0DE, 16'h0000, 2'h0, i[0]);
			a = fall(4, st);
			chk(lowrun(4, a), ln[i] * per);
			chk(falls(0, st), nb[i]);
			chk(fall(i[0] ? 3 : 2, st), -1);
			chk(fall(5, st), i[0] ? a : -1);
			chk(lowrun(5, a), i[0] ? ln[i] * per : 0);
		end
		$display("dma test done");
	endtask

	// Clock enable low must hold the bus clock still
	task automatic t_freeze;
		int s;
		@(posedge ref_clk);
		clk_en <= 1'b0;
		@(negedge ref_clk);
		s = hn;
		repeat (8) @(negedge ref_clk);
		chk(falls(12, s), 0);
		@(posedge ref_clk);
		clk_en <= 1'b1;
		$display("clock enable test done");
	endtask

	initial
	begin
		sys_rst = 1'b1;
		clk_en = 1'b1;
		bclk_div_sel = 2'h0;
		periph_width_sel = 1'b0;
		mem_width_sel = 2'h0;
		addr_auto_step = 1'b0;
		cs_line_cfg = 4'h1;
		gpo_level = 4'h0;
		cmd_valid = 1'b0;
		cmd = '0;
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_pwrite();
		t_dram();
		t_refresh();
		t_dma();
		t_freeze();
		tally_and_finish();
	end
endmodule

// ==== logic/bus_clock_divider.sv ====
`timescale 1ns/1ps
`include "dram_seq_defs.svh"

module bus_clock_divider
	import dram_seq_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	// Ratio select
	input  wire logic [1:0] div_sel,
	// Bus clock and its step pulse
	output logic            tick,
	output logic            bus_clk
);

	logic [2:0] cnt_ff;
	wire  [2:0] div_last;
	wire  [2:0] half;
	wire        wrap;

	assign div_last = (div_sel == `DIV_SEL_2) ? `DIV_LAST_2 :
	                  (div_sel == `DIV_SEL_3) ? `DIV_LAST_3 :
	                  (div_sel == `DIV_SEL_5) ? `DIV_LAST_5 : `DIV_LAST_6;
	assign half     = 3'((div_last + 3'h1) >> 1);
	assign wrap     = (cnt_ff >= div_last);

	// ----------------------------------------
	// Divider
	// ----------------------------------------
	// Sequencer steps on tick except when leaving S_D_RHI, so every other step is a whole bus period
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt_ff  <= 3'h0;
			tick    <= 1'b0;
			bus_clk <= 1'b0;
		end
		else if (clk_en)
		begin
			cnt_ff  <= wrap ? 3'h0 : 3'(cnt_ff + 3'h1);
			tick    <= wrap;
			bus_clk <= (cnt_ff < half);
		end
	end

endmodule

// ==== logic/dram_seq_defs.svh ====
`ifndef DRAM_SEQ_DEFS_SVH
`define DRAM_SEQ_DEFS_SVH

// ----------------------------------------
// Bus clock divider, last count per code
// ----------------------------------------
`define DIV_SEL_2          2'h0
`define DIV_SEL_3          2'h1
`define DIV_SEL_5          2'h2
`define DIV_LAST_2         3'h1
`define DIV_LAST_3         3'h2
`define DIV_LAST_5         3'h4
`define DIV_LAST_6         3'h5

// ----------------------------------------
// Sequence timing, in bus clock periods
// ----------------------------------------
`define PW_STROBE_BCLK     2'h2
`define REF_ROW_LOW_BCLK   2'h2
`define REF_ROW_HIGH_BCLK  2'h2
`define DMA_LEN_SAME_BCLK  5'h10
`define DMA_LEN_HALF_BCLK  5'h13
`define DMA_LEN_QUART_BCLK 5'h19

// ----------------------------------------
// Widths in bits
// ----------------------------------------
`define XFER_NARROW_BITS   5'h08
`define XFER_WIDE_BITS     5'h10
`define MEM_NIBBLE_BITS    5'h04
`define MEM_BYTE_BITS      5'h08
`define MEM_WORD_BITS      5'h10
`define ROW_COL_BITS       10

`endif

// ==== logic/dram_seq_pkg.sv ====
package dram_seq_pkg;

	typedef enum logic [2:0] {
		K_PWR    = 3'b000,
		K_MRD    = 3'b001,
		K_MWR    = 3'b010,
		K_REF    = 3'b011,
		K_DMA_RD = 3'b100,
		K_DMA_WR = 3'b101
	} op_kind_t;

	typedef struct packed {
		op_kind_t    kind;
		logic [1:0]  target;
		logic        addr_load;
		logic        last;
		logic [19:0] addr;
		logic [15:0] data;
	} seq_cmd_t;

	typedef enum logic [3:0] {
		S_IDLE   = 4'b0000,
		S_P_SEL  = 4'b0001,
		S_P_STB  = 4'b0010,
		S_P_HOLD = 4'b0011,
		S_D_ROW  = 4'b0100,
		S_D_RAS  = 4'b0101,
		S_D_COL  = 4'b0110,
		S_D_CAS  = 4'b0111,
		S_D_INC  = 4'b1000,
		S_D_PRE  = 4'b1001,
		S_D_RHI  = 4'b1010,
		S_D_WAIT = 4'b1011,
		S_R_CAS  = 4'b1100,
		S_R_BOTH = 4'b1101,
		S_R_REC  = 4'b1110
	} seq_state_t;

	typedef struct packed {
		logic [2:0] beats;
		logic [4:0] unit_bits;
		logic [4:0] dma_len;
	} width_plan_t;

endpackage

// ==== logic/peripheral_bus_dram_sequencer.sv ====
// Overview of operation
// - Peripheral write strobe falls one bus period after chip select falls.
// - The output configured as chip select and named by the target follows the select timing.
// - Peripheral write strobe stays low for two bus periods.
// - Write data driven one period after select, held one period past strobe.
// - Chip select releases one bus period after the write strobe rises.
// - With auto step set, address advances one period after strobe rises.
// - Narrow DRAM is filled with consecutive fast page beats, DMA and host.
// - Ten bit row address, then read or write strobe one period later.
// - Row strobe falls one bus period after the row address is valid.
// - Column address one period after row strobe, column strobe one later.
// - Read latches data and steps column one period after column strobe.
// - Column strobe stays high one bus period between page beats.
// - Read or write strobe rises within one system clock after both strobes rise.
// - Refresh: column strobe first, low three and two, high one and two periods.
// - Width bit picks 16-bit peripheral; size field 00 nibble, 01 byte, 1x word.
// - DMA cycle lasts 16, 19 or 25 bus periods by width ratio.
// - Terminal count rises with acknowledge of the final DMA transfer.
`timescale 1ns/1ps
`include "dram_seq_defs.svh"

module peripheral_bus_dram_sequencer
	import dram_seq_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	// Configuration
	input  wire logic [1:0]  bclk_div_sel,
	input  wire logic        periph_width_sel,
	input  wire logic [1:0]  mem_width_sel,
	input  wire logic        addr_auto_step,
	input  wire logic [3:0]  cs_line_cfg,
	input  wire logic [3:0]  gpo_level,
	// Command
	input  wire logic        cmd_valid,
	input  wire seq_cmd_t    cmd,
	output logic             cmd_ready,
	output logic [15:0]      rd_data,
	output logic             rd_valid,
	// DMA
	output logic             dma_ack_n,
	output logic             term_count,
	// Peripheral and DRAM pins
	output logic             bus_clk,
	output logic [3:0]       periph_select_n,
	output logic             periph_write_strobe_n,
	output logic             periph_read_strobe_n,
	input  wire logic        wide_transfer_n,
	output logic [7:0]       sys_addr_low,
	output logic [1:0]       mem_addr_high,
	output logic             row_strobe_n,
	output logic             column_strobe_n,
	input  wire logic [15:0] sys_data_bus_in,
	output logic [15:0]      sys_data_bus_out,
	output logic [1:0]       sys_data_bus_oe
);

	seq_state_t  state_ff;
	seq_state_t  nxt_state;
	seq_cmd_t    op_ff;
	width_plan_t plan;
	logic        pend_ff;
	logic [1:0]  hold_ff;
	logic [2:0]  beat_ff;
	logic [9:0]  col_ff;
	logic [7:0]  paddr_ff;
	logic [4:0]  ph_cnt_ff;
	logic [15:0] rd_buf_ff;
	logic        tick;
	logic        bus_clk_w;

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	bus_clock_divider u_div (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.div_sel (bclk_div_sel),
		.tick    (tick),
		.bus_clk (bus_clk_w)
	);

	wire is_dma    = op_ff.kind[2];
	wire mem_write = (op_ff.kind == K_MWR) || (op_ff.kind == K_DMA_WR);

	width_planner u_plan (
		.periph_width_sel (periph_width_sel),
		.mem_width_sel    (mem_width_sel),
		.host_access      (!is_dma),
		.plan             (plan)
	);

	// ----------------------------------------
	// Sequencing
	// ----------------------------------------
	wire take      = cmd_valid && cmd_ready;
	wire start     = tick && pend_ff && (state_ff == S_IDLE);
	// Beat count has already stepped past the current beat by precharge
	wire beat_last = (beat_ff == plan.beats);
	wire dma_done  = (ph_cnt_ff == 5'(plan.dma_len - 5'h1));

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE:   if (start)
			          begin
			          	nxt_state = (op_ff.kind == K_PWR) ? S_P_SEL :
			          	            (op_ff.kind == K_REF) ? S_R_CAS : S_D_ROW;
			          end
			S_P_SEL:  if (tick) nxt_state = S_P_STB;
			S_P_STB:  if (tick && hold_ff == 2'(`PW_STROBE_BCLK - 2'h1)) nxt_state = S_P_HOLD;
			S_P_HOLD: if (tick) nxt_state = S_IDLE;
			S_D_ROW:  if (tick) nxt_state = S_D_RAS;
			S_D_RAS:  if (tick) nxt_state = S_D_COL;
			S_D_COL:  if (tick) nxt_state = S_D_CAS;
			S_D_CAS:  if (tick) nxt_state = S_D_INC;
			S_D_INC:  if (tick) nxt_state = S_D_PRE;
			S_D_PRE:  if (tick) nxt_state = beat_last ? S_D_RHI : S_D_CAS;
			// Strobe release needs no bus edge, only one system clock
			S_D_RHI:  nxt_state = is_dma ? S_D_WAIT : S_IDLE;
			S_D_WAIT: if (tick && dma_done) nxt_state = S_IDLE;
			S_R_CAS:  if (tick) nxt_state = S_R_BOTH;
			S_R_BOTH: if (tick && hold_ff == 2'(`REF_ROW_LOW_BCLK - 2'h1)) nxt_state = S_R_REC;
			S_R_REC:  if (tick && hold_ff == 2'(`REF_ROW_HIGH_BCLK - 2'h1)) nxt_state = S_IDLE;
			default:  nxt_state = S_IDLE;
		endcase
	end

	wire        step_col  = tick && (state_ff == S_D_CAS);
	wire        pw_end    = tick && (state_ff == S_P_HOLD);
	wire [1:0]  nxt_hold  = (nxt_state != state_ff) ? 2'h0 : (tick ? 2'(hold_ff + 2'h1) : hold_ff);
	wire [2:0]  nxt_beat  = start ? 3'h0 : (step_col ? 3'(beat_ff + 3'h1) : beat_ff);
	wire [9:0]  nxt_col   = start ? op_ff.addr[9:0] : (step_col ? 10'(col_ff + 10'h001) : col_ff);
	wire        load_pa   = start && (op_ff.kind == K_PWR) && op_ff.addr_load;
	wire [7:0]  nxt_paddr = load_pa ? op_ff.addr[7:0] :
	                        (pw_end && addr_auto_step) ? 8'(paddr_ff + 8'h01) : paddr_ff;
	wire [4:0]  nxt_ph    = start ? 5'h00 : (tick ? 5'(ph_cnt_ff + 5'h01) : ph_cnt_ff);

	// Lane of the current beat within the assembled word
	wire [3:0]  lane_shift = 4'(beat_ff * plan.unit_bits);
	wire [15:0] lane_mask  = 16'(16'((16'h0001 << plan.unit_bits) - 16'h0001) << lane_shift);
	wire [15:0] rd_merge   = (rd_buf_ff & ~lane_mask) | ((sys_data_bus_in << lane_shift) & lane_mask);
	wire [3:0]  wr_shift   = 4'(nxt_beat * plan.unit_bits);

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_ff  <= S_IDLE;
			op_ff     <= '0;
			pend_ff   <= 1'b0;
			hold_ff   <= 2'h0;
			beat_ff   <= 3'h0;
			col_ff    <= 10'h000;
			paddr_ff  <= 8'h00;
			ph_cnt_ff <= 5'h00;
			rd_buf_ff <= 16'h0000;
		end
		else if (clk_en)
		begin
			state_ff  <= nxt_state;
			op_ff     <= take ? cmd : op_ff;
			pend_ff   <= take || (pend_ff && !start);
			hold_ff   <= nxt_hold;
			beat_ff   <= nxt_beat;
			col_ff    <= nxt_col;
			paddr_ff  <= nxt_paddr;
			ph_cnt_ff <= nxt_ph;
			rd_buf_ff <= (step_col && !mem_write) ? rd_merge : rd_buf_ff;
		end
	end

	// ----------------------------------------
	// Pin decode from next state
	// ----------------------------------------
	wire n_sel   = (nxt_state == S_P_SEL) || (nxt_state == S_P_STB) || (nxt_state == S_P_HOLD);
	wire n_mstb  = (nxt_state >= S_D_RAS) && (nxt_state <= S_D_RHI);
	wire n_ras   = ((nxt_state >= S_D_RAS) && (nxt_state <= S_D_PRE)) || (nxt_state == S_R_BOTH);
	wire n_cas   = (nxt_state == S_D_CAS) || (nxt_state == S_D_INC) ||
	               (nxt_state == S_R_CAS) || (nxt_state == S_R_BOTH);
	wire n_row   = (nxt_state == S_D_ROW) || (nxt_state == S_D_RAS);
	wire n_dram  = (nxt_state >= S_D_ROW) && (nxt_state <= S_D_RHI);
	wire n_pdat  = (nxt_state == S_P_STB) || (nxt_state == S_P_HOLD);
	wire n_mdat  = (op_ff.kind == K_MWR) && (nxt_state >= S_D_COL) && (nxt_state <= S_D_PRE);
	wire n_wide  = n_pdat ? (periph_width_sel && !wide_transfer_n) : (plan.unit_bits == `MEM_WORD_BITS);
	wire n_idle  = (nxt_state == S_IDLE);
	wire [9:0] n_maddr = n_row ? op_ff.addr[19:10] : nxt_col;
	wire [3:0] n_cs_n;

	// DMA moves data directly between peripheral and DRAM, so it never drives data
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_cs
			assign n_cs_n[g] = cs_line_cfg[g] ? !(n_sel && (op_ff.target == 2'(g))) : gpo_level[g];
		end
	endgenerate

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cmd_ready             <= 1'b0;
			rd_data               <= 16'h0000;
			rd_valid              <= 1'b0;
			dma_ack_n             <= 1'b1;
			term_count            <= 1'b0;
			bus_clk               <= 1'b0;
			periph_select_n       <= 4'hF;
			periph_write_strobe_n <= 1'b1;
			periph_read_strobe_n  <= 1'b1;
			sys_addr_low          <= 8'h00;
			mem_addr_high         <= 2'h0;
			row_strobe_n          <= 1'b1;
			column_strobe_n       <= 1'b1;
			sys_data_bus_out      <= 16'h0000;
			sys_data_bus_oe       <= 2'h0;
		end
		else if (clk_en)
		begin
			cmd_ready             <= n_idle && !(take || (pend_ff && !start));
			rd_data               <= rd_buf_ff;
			rd_valid              <= (state_ff == S_D_RHI) && (op_ff.kind == K_MRD);
			dma_ack_n             <= !(is_dma && !n_idle);
			term_count            <= is_dma && !n_idle && op_ff.last;
			bus_clk               <= bus_clk_w;
			periph_select_n       <= n_cs_n;
			periph_write_strobe_n <= !((nxt_state == S_P_STB) || (n_mstb && mem_write));
			periph_read_strobe_n  <= !(n_mstb && !mem_write);
			sys_addr_low          <= n_dram ? n_maddr[7:0] : nxt_paddr;
			mem_addr_high         <= n_dram ? n_maddr[9:8] : 2'h0;
			row_strobe_n          <= !n_ras;
			column_strobe_n       <= !n_cas;
			sys_data_bus_out      <= n_pdat ? op_ff.data : (op_ff.data >> wr_shift);
			sys_data_bus_oe       <= {(n_pdat || n_mdat) && n_wide, n_pdat || n_mdat};
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	wire pw_op   = (op_ff.kind == K_PWR);
	wire dram_op = (op_ff.kind != K_PWR) && (op_ff.kind != K_REF);
	wire sel_any = (state_ff == S_P_SEL) || (state_ff == S_P_STB) || (state_ff == S_P_HOLD);

	// Bus edges seen with the column strobe high; precharge length for any ratio
	logic [2:0] cas_hi_ticks_ff;

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			cas_hi_ticks_ff <= 3'h0;
		else if (clk_en)
			cas_hi_ticks_ff <= column_strobe_n ? 3'(cas_hi_ticks_ff + {2'h0, tick}) : 3'h0;
	end

	chk_sel_to_strobe: assert property (
		$fell(periph_write_strobe_n) && pw_op |-> ph_cnt_ff == 5'h01 && sel_any)
		else $error("write strobe not one bus period after select");
	chk_strobe_width: assert property (
		$rose(periph_write_strobe_n) && pw_op |-> ph_cnt_ff == 5'h03)
		else $error("write strobe width not two bus periods");
	chk_data_hold: assert property (
		$rose(periph_write_strobe_n) && pw_op |-> sys_data_bus_oe[0] && $stable(sys_data_bus_out))
		else $error("write data not held past strobe");
	chk_sel_release: assert property (
		$fell(sel_any) && pw_op |-> ph_cnt_ff == 5'h04 && !sys_data_bus_oe[0])
		else $error("select not released one period after strobe");
	chk_addr_step: assert property (
		$fell(sel_any) && pw_op |-> sys_addr_low == 8'($past(sys_addr_low) + {7'h00, addr_auto_step}))
		else $error("peripheral address step wrong");
	chk_row_to_ras: assert property (
		$fell(row_strobe_n) && dram_op |-> ph_cnt_ff == 5'h01 && !(periph_read_strobe_n && periph_write_strobe_n))
		else $error("row strobe or access strobe mistimed");
	chk_col_to_cas: assert property (
		$fell(column_strobe_n) && dram_op && beat_ff == 3'h0 |-> ph_cnt_ff == 5'h03)
		else $error("first column strobe mistimed");
	chk_cas_precharge: assert property (
		$fell(column_strobe_n) && dram_op && beat_ff != 3'h0 |-> cas_hi_ticks_ff == 3'h1)
		else $error("column strobe precharge not one bus period");
	chk_refresh_order: assert property (
		$fell(row_strobe_n) && op_ff.kind == K_REF |-> !column_strobe_n && ph_cnt_ff == 5'h01)
		else $error("refresh row strobe not after column strobe");
	chk_strobe_release: assert property (
		$rose(row_strobe_n) && dram_op |=> periph_read_strobe_n && periph_write_strobe_n)
		else $error("access strobe held after row strobe rose");
	chk_tc_with_ack: assert property (
		$fell(dma_ack_n) |-> term_count == op_ff.last)
		else $error("terminal count not with acknowledge");
	chk_cas_low_width: assert property (
		$rose(column_strobe_n) && dram_op |-> ph_cnt_ff == 5'(5'h03 * {2'h0, beat_ff} + 5'h02))
		else $error("column strobe low time wrong");
	chk_dma_length: assert property (
		$rose(dma_ack_n) |-> ph_cnt_ff == plan.dma_len)
		else $error("acknowledge length not the planned bus periods");

	cov_periph_write: cover property ($rose(sel_any) && pw_op);
	cov_page_beats:   cover property ($fell(column_strobe_n) && dram_op && beat_ff == 3'h3);
	cov_refresh:      cover property ($fell(row_strobe_n) && op_ff.kind == K_REF);
	cov_dma_last:     cover property ($fell(dma_ack_n) && op_ff.last);

endmodule

// ==== logic/width_planner.sv ====
`timescale 1ns/1ps
`include "dram_seq_defs.svh"

module width_planner
	import dram_seq_pkg::*;
(
	// Width selection
	input  wire logic       periph_width_sel,
	input  wire logic [1:0] mem_width_sel,
	input  wire logic       host_access,
	// Derived plan
	output width_plan_t     plan
);

	wire [4:0] xfer_bits;
	wire [4:0] unit_bits;
	wire       quarter;
	wire       halved;

	// Host side is always a byte wide
	assign xfer_bits = (periph_width_sel && !host_access) ? `XFER_WIDE_BITS : `XFER_NARROW_BITS;
	assign unit_bits = mem_width_sel[1] ? `MEM_WORD_BITS :
	                   mem_width_sel[0] ? `MEM_BYTE_BITS : `MEM_NIBBLE_BITS;
	assign quarter   = (xfer_bits == `XFER_WIDE_BITS) && (unit_bits == `MEM_NIBBLE_BITS);
	assign halved    = !quarter && (xfer_bits > unit_bits);

	// One driver for the whole plan, fields filled by name
	assign plan = '{beats:     quarter ? 3'h4 : halved ? 3'h2 : 3'h1,
	                unit_bits: unit_bits,
	                dma_len:   quarter ? `DMA_LEN_QUART_BCLK :
	                           halved  ? `DMA_LEN_HALF_BCLK  : `DMA_LEN_SAME_BCLK};

endmodule
